// [core/timer_one_map.vh]
// Register map, field positions, reset values and rate constants of the timer block.
// Assumes inclusion by bare name from files under core/.
`ifndef TIMER_ONE_MAP_VH
`define TIMER_ONE_MAP_VH

// Byte addresses on the AHB-Lite register bus
`define ADDR_CONTROL      8'h10
`define ADDR_COUNT_LOW    8'h14
`define ADDR_COUNT_HIGH   8'h18
`define ADDR_IRQ_STATUS   8'h1c
`define ADDR_IRQ_MASK     8'h20

// Control register fields
`define CTL_ON_BIT        0
`define CTL_CS_BIT        1
`define CTL_SYNC_BIT      2
`define CTL_OSCEN_BIT     3
`define CTL_PS_LO         4
`define CTL_PS_HI         5
`define CTL_RUN_BIT       6
`define CTL_WR_MASK       6'h3f
`define CTL_RESET         6'h00

// Prescale codes
`define PS_DIV1           2'h0
`define PS_DIV2           2'h1
`define PS_DIV4           2'h2
`define PS_DIV8           2'h3

// Interrupt status and mask
`define IRQ_OVF_BIT       0
`define IRQ_RESET         1'h0

// Count register pair
`define COUNT_RESET       16'h0000
`define COUNT_TOP         16'hffff

// Instruction cycle is one quarter of the oscillator (mclk) rate
`define INSTR_DIV         2'h3

`endif

// [core/pin_edge_detect.v]
// Rising and falling edge detector for a level that is already synchronous to mclk.
// Assumes the input changes only after rising edges of mclk.
`default_nettype none

module pin_edge_detect (
    input  wire mclk,
    input  wire rst_n,
    input  wire level,
    output wire rise,
    output wire fall
);
    reg prev_q;

    always @(posedge mclk) begin
        if (!rst_n) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= level;
        end
    end

    assign rise = level & ~prev_q;
    assign fall = ~level & prev_q;
endmodule

`default_nettype wire

// [core/count_prescaler.v]
// Input prescaler: passes one tick in every 1, 2, 4 or 8 input ticks.
// Assumes tickIn is a one-cycle enable; clear wins over a tick in the same cycle.
`default_nettype none
`include "timer_one_map.vh"

module count_prescaler #(
    parameter WIDTH = 3
) (
    input  wire       mclk,
    input  wire       rst_n,
    input  wire       clear,
    input  wire       tickIn,
    input  wire [1:0] select,
    output wire       tickOut
);
    reg  [WIDTH-1:0] cnt_q;
    reg  [WIDTH-1:0] mask;

    always @* begin
        case (select)
            `PS_DIV1: mask = {WIDTH{1'b0}};
            `PS_DIV2: mask = {{(WIDTH-1){1'b0}}, 1'b1};
            `PS_DIV4: mask = {{(WIDTH-2){1'b0}}, 2'b11};
            `PS_DIV8: mask = {WIDTH{1'b1}};
            default:  mask = {WIDTH{1'b0}};
        endcase
    end

    assign tickOut = tickIn & ((cnt_q & mask) == mask);

    always @(posedge mclk) begin
        if (!rst_n || clear) begin
            cnt_q <= {WIDTH{1'b0}};
        end else if (tickIn) begin
            cnt_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
endmodule

`default_nettype wire

// [core/timer_counter_core.v]
// 16-bit timer/counter with control register, prescaler and overflow interrupt.
// Assumes an AHB-Lite master on mclk and pin inputs already synchronous to mclk.
// Function
// - Control bit 1 picks internal timing or external counting.
// - With bit 1 clear the count advances once per instruction cycle (mclk/4).
// - With bit 1 set the count advances on rising edges of the external clock.
// - In counter mode a set sync bypass passes edges directly, a clear one aligns them.
// - In timer mode the sync bypass bit has no effect.
// - Prescale code 11 divides by 8 and code 10 by 4.
// - With the oscillator on, its two port pins are inputs and read as zero.
// - Control bit 6 is read-only and shows the system clock comes from the oscillator.
// - The compare unit's trigger clears the count.
// - Control bit 7 ignores writes and reads zero.
// - The count wraps from ffff to 0000 and each wrap sets the overflow flag.
// - After enabling counter mode, a falling edge must come before counting starts.
// - Writing either count byte clears the prescaler.
// - The control register resets to 00h.
//
// Chosen here: register access over AHB-Lite.
`default_nettype none
`include "timer_one_map.vh"

module timer_counter_core #(
    parameter PRESCALE_WIDTH = 3
) (
    input  wire        mclk,
    input  wire        rst_n,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire        extClkPin,
    input  wire        oscInPin,
    input  wire        compareTrigger,
    input  wire        sysclkFromLowPowerOsc,
    input  wire [1:0]  portDirBits,
    input  wire [1:0]  portPinLevels,
    output reg  [1:0]  portDirEffective,
    output reg  [1:0]  portReadData,
    output reg         oscAmpEnable,
    output reg         irq
);
    // Control and status state
    reg  [5:0]  control_q;
    reg  [15:0] count_q;
    reg  [15:0] count_d;
    reg         ovfStatus_q;
    reg         ovfMask_q;
    reg  [1:0]  divCnt_q;
    reg         armed_q;
    reg         syncPend_q;

    // Bus data phase
    reg         wrPend_q;
    reg  [7:0]  wrAddr_q;
    reg  [31:0] readMux;

    wire        countEnable   = control_q[`CTL_ON_BIT];
    wire        countSource   = control_q[`CTL_CS_BIT];
    wire        extSyncBypass = control_q[`CTL_SYNC_BIT];
    wire        lowPowerOscEn = control_q[`CTL_OSCEN_BIT];
    wire [1:0]  prescaleSel   = control_q[`CTL_PS_HI:`CTL_PS_LO];

    wire        addrPhase = hsel & htrans[1] & hready;
    wire        wrCtrl    = wrPend_q & (wrAddr_q == `ADDR_CONTROL);
    wire        wrLow     = wrPend_q & (wrAddr_q == `ADDR_COUNT_LOW);
    wire        wrHigh    = wrPend_q & (wrAddr_q == `ADDR_COUNT_HIGH);
    wire        wrStatus  = wrPend_q & (wrAddr_q == `ADDR_IRQ_STATUS);
    wire        wrMask    = wrPend_q & (wrAddr_q == `ADDR_IRQ_MASK);
    wire        countWrite = wrLow | wrHigh;

    // Instruction cycle divider, free running
    wire        instrTick = (divCnt_q == `INSTR_DIV);

    always @(posedge mclk) begin
        if (!rst_n) begin
            divCnt_q <= 2'h0;
        end else begin
            divCnt_q <= divCnt_q + 2'h1;
        end
    end

    // External source: oscillator input when the oscillator runs, else the clock pin
    wire        extLevel = lowPowerOscEn ? oscInPin : extClkPin;
    wire        extRise;
    wire        extFall;

    pin_edge_detect extEdge (
        .mclk  (mclk),
        .rst_n (rst_n),
        .level (extLevel),
        .rise  (extRise),
        .fall  (extFall)
    );

    // Counting must not start on a rising edge seen before the first falling edge
    wire        counterRun = countEnable & countSource;

    always @(posedge mclk) begin
        if (!rst_n) begin
            armed_q <= 1'b0;
        end else if (!counterRun) begin
            armed_q <= 1'b0;
        end else if (extFall) begin
            armed_q <= 1'b1;
        end
    end

    // Source tick into the prescaler
    reg         srcTick;

    always @* begin
        if (!countEnable) begin
            srcTick = 1'b0;
        end else if (countSource) begin
            srcTick = extRise & armed_q;
        end else begin
            srcTick = instrTick;
        end
    end

    wire        presTick;

    count_prescaler #(
        .WIDTH (PRESCALE_WIDTH)
    ) prescaler (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .clear   (countWrite),
        .tickIn  (srcTick),
        .select  (prescaleSel),
        .tickOut (presTick)
    );

    // Synchronised counter mode holds a prescaled tick until the next instruction cycle
    wire        syncMode = countSource & ~extSyncBypass;
    reg         incTick;

    always @* begin
        if (!countEnable) begin
            incTick = 1'b0;
        end else if (syncMode) begin
            incTick = instrTick & (presTick | syncPend_q);
        end else begin
            incTick = presTick;
        end
    end

    always @(posedge mclk) begin
        if (!rst_n || !syncMode || !countEnable || countWrite) begin
            syncPend_q <= 1'b0;
        end else if (presTick & ~instrTick) begin
            syncPend_q <= 1'b1;
        end else if (instrTick) begin
            syncPend_q <= 1'b0;
        end
    end

    // Count register: a bus write beats the trigger, the trigger beats an increment
    wire        wrap = incTick & (count_q == `COUNT_TOP);

    always @* begin
        count_d = count_q;
        if (wrLow) begin
            count_d[7:0] = hwdata[7:0];
        end else if (wrHigh) begin
            count_d[15:8] = hwdata[7:0];
        end else if (compareTrigger) begin
            count_d = `COUNT_RESET;
        end else if (incTick) begin
            count_d = count_q + 16'h0001;
        end
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            count_q <= `COUNT_RESET;
        end else begin
            count_q <= count_d;
        end
    end

    // Control register; only power-on reset reaches it
    always @(posedge mclk) begin
        if (!rst_n) begin
            control_q <= `CTL_RESET;
        end else if (wrCtrl) begin
            control_q <= hwdata[5:0] & `CTL_WR_MASK;
        end
    end

    // Overflow flag: a wrap in the same cycle as a write-one-to-clear keeps it set
    always @(posedge mclk) begin
        if (!rst_n) begin
            ovfStatus_q <= `IRQ_RESET;
        end else if (wrap) begin
            ovfStatus_q <= 1'b1;
        end else if (wrStatus && hwdata[`IRQ_OVF_BIT]) begin
            ovfStatus_q <= 1'b0;
        end
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            ovfMask_q <= `IRQ_RESET;
        end else if (wrMask) begin
            ovfMask_q <= hwdata[`IRQ_OVF_BIT];
        end
    end

    always @(posedge mclk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= ovfStatus_q & ovfMask_q;
        end
    end

    // Oscillator and shared port pins
    always @(posedge mclk) begin
        if (!rst_n) begin
            oscAmpEnable     <= 1'b0;
            portDirEffective <= 2'h3;
            portReadData     <= 2'h0;
        end else begin
            oscAmpEnable <= lowPowerOscEn;
            if (lowPowerOscEn) begin
                portDirEffective <= 2'h3;
                portReadData     <= 2'h0;
            end else begin
                portDirEffective <= portDirBits;
                portReadData     <= portPinLevels;
            end
        end
    end

    // Read mux, sampled at the address phase so data stand through the data phase
    always @* begin
        readMux = 32'h00000000;
        case (haddr[7:0])
            `ADDR_CONTROL: begin
                readMux[5:0]          = control_q;
                readMux[`CTL_RUN_BIT] = sysclkFromLowPowerOsc;
                readMux[7]            = 1'b0;
            end
            `ADDR_COUNT_LOW: begin
                readMux[7:0] = count_q[7:0];
            end
            `ADDR_COUNT_HIGH: begin
                readMux[7:0] = count_q[15:8];
            end
            `ADDR_IRQ_STATUS: begin
                readMux[`IRQ_OVF_BIT] = ovfStatus_q;
            end
            `ADDR_IRQ_MASK: begin
                readMux[`IRQ_OVF_BIT] = ovfMask_q;
            end
            default: begin
                readMux = 32'h00000000;
            end
        endcase
        if (haddr[31:8] != 24'h000000) begin
            readMux = 32'h00000000;
        end
    end

    // Zero-wait AHB-Lite slave; unmapped addresses read zero and ignore writes
    always @(posedge mclk) begin
        if (!rst_n) begin
            wrPend_q  <= 1'b0;
            wrAddr_q  <= 8'h00;
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wrPend_q  <= addrPhase & hwrite & (haddr[31:8] == 24'h000000);
            wrAddr_q  <= haddr[7:0];
            if (addrPhase && !hwrite) begin
                hrdata <= readMux;
            end
        end
    end
endmodule

`default_nettype wire

// [verif/timer_counter_chk.sv]
// Checker: bus, pin-mirror and interrupt relations at the timer block's ports.
// Assumes it is bound to timer_counter_core and sees only that module's ports.
`default_nettype none
`include "timer_one_map.vh"

module timer_counter_chk (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [1:0]  portDirBits,
    input wire logic [1:0]  portPinLevels,
    input wire logic [1:0]  portDirEffective,
    input wire logic [1:0]  portReadData,
    input wire logic        oscAmpEnable,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic takeRd;
    assign takeRd = hsel && htrans[1] && hready && !hwrite;
    sequence s_wrAddr(a);
        hsel && htrans[1] && hready && hwrite && haddr == a;
    endsequence
    sequence s_rdAddr(a);
        takeRd && haddr == a;
    endsequence
    property p_ready;
        hreadyout && !hresp;
    endproperty
    a_ready: assert property (p_ready) else $error("slave stalled or errored");
    property p_hold;
        !takeRd |=> $stable(hrdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved without a read");
    property p_unmapped;
        takeRd && !(haddr inside {8'h10, 8'h14, 8'h18, 8'h1c, 8'h20}) |=> hrdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_ctlTop;
        s_rdAddr(`ADDR_CONTROL) |=> hrdata[31:7] == 25'h0;
    endproperty
    a_ctlTop: assert property (p_ctlTop) else $error("control top bits not zero");
    property p_oscFollow;
        s_wrAddr(`ADDR_CONTROL) ##1 1'b1 |-> ##2 oscAmpEnable == $past(hwdata[3], 2);
    endproperty
    a_oscFollow: assert property (p_oscFollow) else $error("oscillator enable wrong");
    property p_irqMask;
        s_wrAddr(`ADDR_IRQ_MASK) ##1 !hwdata[0] |-> ##2 !irq;
    endproperty
    a_irqMask: assert property (p_irqMask) else $error("masked interrupt still high");
    property p_dirOsc;
        oscAmpEnable && $past(oscAmpEnable) |-> portDirEffective == 2'h3 && portReadData == 2'h0;
    endproperty
    a_dirOsc: assert property (p_dirOsc) else $error("shared pins not forced");
    property p_dirPass;
        $past(rst_n) && !oscAmpEnable && !$past(oscAmpEnable) |->
            portDirEffective == $past(portDirBits) && portReadData == $past(portPinLevels);
    endproperty
    a_dirPass: assert property (p_dirPass) else $error("shared pins not passed");
endmodule

`default_nettype wire

// [verif/ext_clk_src.sv]
// External count source: a square wave on the pin picked by sel while run is high.
// Assumes edges must land just after rising edges of mclk.
`default_nettype none

module ext_clk_src (
    input  wire logic       mclk,
    input  wire logic       run,
    input  wire logic       sel,
    output logic            extClkPin,
    output logic            oscInPin,
    output logic [7:0]      risesMade
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       wave = 1'b0;
    logic [1:0] phase = 2'h0;
    initial risesMade = 8'h0;
    // Stands low between bursts, so every burst opens with an unarmed rising edge
    always @(posedge mclk) begin
        if (!run) begin
            wave <= 1'b0;
            phase <= 2'h0;
        end else if (phase == 2'h2) begin
            phase <= 2'h0;
            wave <= !wave;
            risesMade <= risesMade + {7'h0, !wave};
        end else begin
            phase <= phase + 2'h1;
        end
    end
    assign extClkPin = wave & !sel;
    assign oscInPin  = wave & sel;
endmodule

`default_nettype wire

// [verif/tb.sv]
// Top testbench: drives the timer block over AHB-Lite and its pins, checks what it reports.
// Assumes core/ is on the include path; model and checker are compiled first.
`default_nettype none
`include "timer_one_map.vh"

module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] EXT_CFG [3] = '{8'h03, 8'h07, 8'h0f};
    logic        mclk, rst_n, hsel, hwrite, hreadyout, hresp, extRun, extSel, oscInPin;
    logic        extClkPin, compareTrigger, sysclkFromLowPowerOsc, oscAmpEnable, irq;
    logic [1:0]  htrans, portDirBits, portPinLevels, portDirEffective, portReadData;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [7:0]  risesMade, r0;
    int          errTotal = 0;
    int          numChecks = 0;

    timer_counter_core timer_counter_core_i (
        .mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .extClkPin, .oscInPin,
        .compareTrigger, .sysclkFromLowPowerOsc, .portDirBits, .portPinLevels,
        .portDirEffective, .portReadData, .oscAmpEnable, .irq);
    ext_clk_src ext_clk_src_i (.mclk, .run(extRun), .sel(extSel), .extClkPin, .oscInPin,
        .risesMade);

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            errTotal++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        check(rd, e);
    endtask

    task automatic closeOut;
        if (errTotal == 0 && numChecks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        errTotal++;
        closeOut();
    end

    initial begin
        rst_n = 1'b0;
        hsel = 1'b1;
        hwrite = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        extRun = 1'b0;
        extSel = 1'b0;
        compareTrigger = 1'b0;
        sysclkFromLowPowerOsc = 1'b1;
        portDirBits = 2'h1;
        portPinLevels = 2'h3;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rdchk(`ADDR_CONTROL, 32'h40);
        wr(`ADDR_CONTROL, 32'hbe);
        rdchk(`ADDR_CONTROL, 32'h7e);
        check({27'h0, oscAmpEnable, portDirEffective, portReadData}, 32'h1c);
        sysclkFromLowPowerOsc <= 1'b0;
        wr(`ADDR_CONTROL, 32'h0);
        rdchk(`ADDR_CONTROL, 32'h0);
        check({27'h0, oscAmpEnable, portDirEffective, portReadData}, 32'h7);
        wr(8'h40, 32'hff);
        rdchk(8'h40, 32'h0);
        // Sync bypass set on purpose: timer mode must ignore it
        for (int ps = 0; ps < 4; ps++) begin
            wr(`ADDR_COUNT_LOW, 32'h0);
            wr(`ADDR_COUNT_HIGH, 32'h0);
            wr(`ADDR_CONTROL, {26'h0, ps[1:0], 4'h5});
            repeat (32 * (1 << ps) - 2) @(posedge mclk);
            wr(`ADDR_CONTROL, 32'h0);
            xfer(1'b0, `ADDR_COUNT_LOW, 32'h0);
            check(32'(rd >= 7 && rd <= 9), 32'h1);
            repeat (8) @(posedge mclk);
            rdchk(`ADDR_COUNT_LOW, rd);
        end
        wr(`ADDR_IRQ_MASK, 32'h1);
        wr(`ADDR_COUNT_HIGH, 32'hff);
        wr(`ADDR_COUNT_LOW, 32'hfe);
        wr(`ADDR_CONTROL, 32'h1);
        repeat (40) @(posedge mclk);
        wr(`ADDR_CONTROL, 32'h0);
        rdchk(`ADDR_COUNT_HIGH, 32'h0);
        rdchk(`ADDR_IRQ_STATUS, 32'h1);
        check({31'h0, irq}, 32'h1);
        // Masking a pending flag must drop the line while the flag stays set
        wr(`ADDR_IRQ_MASK, 32'h0);
        rdchk(`ADDR_IRQ_STATUS, 32'h1);
        check({31'h0, irq}, 32'h0);
        wr(`ADDR_IRQ_MASK, 32'h1);
        rdchk(`ADDR_IRQ_MASK, 32'h1);
        check({31'h0, irq}, 32'h1);
        wr(`ADDR_IRQ_STATUS, 32'h1);
        rdchk(`ADDR_IRQ_STATUS, 32'h0);
        check({31'h0, irq}, 32'h0);
        wr(`ADDR_IRQ_MASK, 32'h0);
        wr(`ADDR_COUNT_LOW, 32'h55);
        compareTrigger <= 1'b1;
        @(posedge mclk);
        compareTrigger <= 1'b0;
        rdchk(`ADDR_COUNT_LOW, 32'h0);
        // First rising edge of each burst comes before any falling edge and must not count
        for (int i = 0; i < 3; i++) begin
            wr(`ADDR_COUNT_LOW, 32'h0);
            extSel <= EXT_CFG[i][3];
            wr(`ADDR_CONTROL, {24'h0, EXT_CFG[i]});
            r0 = risesMade;
            extRun <= 1'b1;
            repeat (60) @(posedge mclk);
            extRun <= 1'b0;
            repeat (10) @(posedge mclk);
            wr(`ADDR_CONTROL, 32'h0);
            rdchk(`ADDR_COUNT_LOW, {24'h0, risesMade - r0 - 8'h1});
        end
        // Reset in mid-run must bring control back to its power-on value
        wr(`ADDR_CONTROL, 32'h3f);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rdchk(`ADDR_CONTROL, 32'h0);
        check({27'h0, oscAmpEnable, portDirEffective, portReadData}, 32'h7);
        closeOut();
    end
endmodule

bind timer_counter_core timer_counter_chk timer_counter_chk_i (
    .mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout,
    .hresp, .portDirBits, .portPinLevels, .portDirEffective, .portReadData, .oscAmpEnable,
    .irq);

`default_nettype wire
